// ===== logic/accumulator_op_cmd_pkg.sv
// constants for the accumulator, compare and conditional jump engine
package accumulator_op_cmd_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CMD_HEAD = 8'h00;
  localparam logic [7:0] OFF_CMD_VALUE = 8'h04;
  localparam logic [7:0] OFF_CMD_SUM = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  localparam logic [7:0] OFF_REPLY_HEAD = 8'h10;
  localparam logic [7:0] OFF_REPLY_VALUE = 8'h14;
  localparam logic [7:0] OFF_REPLY_SUM = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_ACC = 8'h20;
  localparam logic [7:0] OFF_PC = 8'h24;
  localparam logic [7:0] OFF_FLAGS = 8'h28;
  // control register fields
  localparam int CTRL_STANDALONE = 0;
  localparam int CTRL_GO = 1;
  localparam int CTRL_HOST_LSB = 8;
  localparam logic [7:0] HOST_ADDR_RESET = 8'h02;
  // instruction numbers
  localparam logic [7:0] INS_WRITE_OUT = 8'h0e;
  localparam logic [7:0] INS_READ_PORT = 8'h0f;
  localparam logic [7:0] INS_ACCUMULATOR_OP_CMD = 8'h13;
  localparam logic [7:0] INS_COMPARE = 8'h14;
  localparam logic [7:0] INS_JUMP_COND = 8'h15;
  // port banks and ports
  localparam logic [7:0] BANK_INPUTS = 8'h00;
  localparam logic [7:0] BANK_OUTPUTS = 8'h02;
  localparam logic [7:0] PORT_ENABLE = 8'h0a;
  localparam int OUT_COUNT = 4;
  // accumulator operation codes
  localparam logic [7:0] OP_ADD = 8'h00;
  localparam logic [7:0] OP_SUB = 8'h01;
  localparam logic [7:0] OP_MUL = 8'h02;
  localparam logic [7:0] OP_DIV = 8'h03;
  localparam logic [7:0] OP_MOD = 8'h04;
  localparam logic [7:0] OP_AND = 8'h05;
  localparam logic [7:0] OP_OR = 8'h06;
  localparam logic [7:0] OP_XOR = 8'h07;
  localparam logic [7:0] OP_NOT = 8'h08;
  localparam logic [7:0] OP_LOAD = 8'h09;
  // jump condition codes
  localparam logic [7:0] CND_ZERO = 8'h00;
  localparam logic [7:0] CND_NOT_ZERO = 8'h01;
  localparam logic [7:0] CND_EQUAL = 8'h02;
  localparam logic [7:0] CND_NOT_EQUAL = 8'h03;
  localparam logic [7:0] CND_GREATER = 8'h04;
  localparam logic [7:0] CND_GREATER_EQUAL = 8'h05;
  localparam logic [7:0] CND_LOWER = 8'h06;
  localparam logic [7:0] CND_LOWER_EQUAL = 8'h07;
  localparam logic [7:0] CND_TIMEOUT = 8'h08;
  localparam logic [7:0] CND_ALARM = 8'h09;
  localparam logic [7:0] CND_DEVIATION = 8'h0a;
  localparam logic [7:0] CND_POSITION = 8'h0b;
  // reply status codes
  localparam logic [7:0] STS_OK = 8'h64;
  localparam logic [7:0] STS_BAD_SUM = 8'h01;
  localparam logic [7:0] STS_BAD_INSTR = 8'h02;
  // error and compare flag bit positions
  localparam int FLG_TIMEOUT = 0;
  localparam int FLG_ALARM = 1;
  localparam int FLG_DEVIATION = 2;
  localparam int FLG_POSITION = 3;
  localparam int FLG_EQ = 4;
  localparam int FLG_GT = 5;
  localparam int FLG_LT = 6;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_REPLY = 3'b100
  } exec_state_t;
endpackage : accumulator_op_cmd_pkg

// ===== logic/accumulator_op_cmd_engine.sv
// accumulator calculate, compare, conditional jump and port read engine
//
// Function
// - bank 2 port read returns output state
// - port 10 bank 0 returns inverted enable
// - instruction 19 updates accumulator with operation
// - codes 0-4 add, sub, mul, div, mod
// - codes 5-7 and/or/xor; 8 inverts
// - code 9 loads operand into accumulator
// - direct reply status 100, value operand
// - reply bytes host,target,status,instr,value,sum
// - instruction 20 compares, sets status flags
// - instruction 21 jumps when condition true
// - codes 0-7 test comparison results
// - codes 8-11 test the error flags
// - wait timeout sets timeout error flag
`timescale 1ns/1ns
`default_nettype none
module accumulator_op_cmd_engine
#(
  parameter logic [7:0] MODULE_ADDR = 8'h01 // arbitrary default
)
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic wait_timeout, // timeout pulse, same clock
  input wire logic alarm_pin, // external alarm pin
  input wire logic deviation_pin, // deviation error pin
  input wire logic position_pin, // position error pin
  input wire logic enable_pin, // module enable pin, high on
  output logic [accumulator_op_cmd_pkg::OUT_COUNT-1:0] gp_out // outputs
);
  import accumulator_op_cmd_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end
    else
    begin
      pin_meta <= {enable_pin, position_pin, deviation_pin, alarm_pin};
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [31:0] cmd_head;
  logic [31:0] cmd_value;
  logic [7:0] cmd_sum;
  logic standalone;
  logic [7:0] host_addr;
  logic [31:0] reply_head;
  logic [31:0] reply_value;
  logic [7:0] reply_sum;
  logic reply_valid;
  logic signed [31:0] acc;
  logic [31:0] pc;
  logic [6:0] flags;
  exec_state_t state;

  wire logic wr_access = psel & penable & pready & pwrite;
  wire logic go = wr_access && paddr == OFF_CTRL && pwdata[CTRL_GO];
  wire logic clr_flags = wr_access && paddr == OFF_FLAGS;

  // ----------------------------------------
  // command fields
  // ----------------------------------------
  wire logic [7:0] f_target = cmd_head[31:24];
  wire logic [7:0] f_instr = cmd_head[23:16];
  wire logic [7:0] f_type = cmd_head[15:8];
  wire logic [7:0] f_bank = cmd_head[7:0];
  wire logic signed [31:0] operand = cmd_value;

  function automatic logic [7:0] sum8(input logic [31:0] a, input logic [31:0] b);
    sum8 = a[31:24] + a[23:16] + a[15:8] + a[7:0] + b[31:24] + b[23:16] + b[15:8] + b[7:0];
  endfunction : sum8

  wire logic sum_ok = sum8(cmd_head, cmd_value) == cmd_sum;
  wire logic for_me = f_target == MODULE_ADDR;

  // ----------------------------------------
  // accumulator operation
  // ----------------------------------------
  logic signed [31:0] next_acc;
  logic [63:0] product;
  always_comb
  begin
    product = 64'(acc * operand);
    next_acc = acc;
    case (f_type)
      OP_ADD: next_acc = acc + operand;
      OP_SUB: next_acc = acc - operand;
      OP_MUL: next_acc = product[31:0];
      OP_DIV: next_acc = (operand == 32'sh0) ? acc : acc / operand;
      OP_MOD: next_acc = (operand == 32'sh0) ? acc : acc % operand;
      OP_AND: next_acc = acc & operand;
      OP_OR: next_acc = acc | operand;
      OP_XOR: next_acc = acc ^ operand;
      OP_NOT: next_acc = ~acc;
      OP_LOAD: next_acc = operand;
      default: next_acc = acc;
    endcase
  end

  // ----------------------------------------
  // jump condition and port read
  // ----------------------------------------
  logic cond_true;
  always_comb
  begin
    case (f_type)
      CND_ZERO: cond_true = flags[FLG_EQ];
      CND_NOT_ZERO: cond_true = !flags[FLG_EQ];
      CND_EQUAL: cond_true = flags[FLG_EQ];
      CND_NOT_EQUAL: cond_true = !flags[FLG_EQ];
      CND_GREATER: cond_true = flags[FLG_GT];
      CND_GREATER_EQUAL: cond_true = !flags[FLG_LT];
      CND_LOWER: cond_true = flags[FLG_LT];
      CND_LOWER_EQUAL: cond_true = !flags[FLG_GT];
      CND_TIMEOUT: cond_true = flags[FLG_TIMEOUT];
      CND_ALARM: cond_true = flags[FLG_ALARM];
      CND_DEVIATION: cond_true = flags[FLG_DEVIATION];
      CND_POSITION: cond_true = flags[FLG_POSITION];
      default: cond_true = 1'b0;
    endcase
  end

  logic [31:0] port_value;
  always_comb
  begin
    port_value = 32'h0;
    if (f_bank == BANK_OUTPUTS && f_type < 8'(OUT_COUNT))
      port_value = {31'h0, gp_out[f_type[1:0]]};
    else if (f_bank == BANK_INPUTS && f_type == PORT_ENABLE)
      port_value = {31'h0, !pin_sync[3]};
  end

  wire logic known = f_instr inside {INS_WRITE_OUT, INS_READ_PORT, INS_ACCUMULATOR_OP_CMD, INS_COMPARE, INS_JUMP_COND};
  wire logic do_run = state == ST_EXEC && for_me && sum_ok && known;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_IDLE;
    else
      case (state)
        ST_IDLE: state <= go ? ST_EXEC : ST_IDLE;
        ST_EXEC: state <= ST_REPLY;
        ST_REPLY: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc <= 32'sh0;
    else if (do_run && f_instr == INS_ACCUMULATOR_OP_CMD)
      acc <= next_acc;
    else if (do_run && f_instr == INS_READ_PORT && standalone)
      acc <= port_value;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pc <= 32'h0;
    else if (do_run && f_instr == INS_JUMP_COND && cond_true)
      pc <= cmd_value;
    else if (do_run)
      pc <= pc + 32'h1;
  end

  // set wins over a software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags <= 7'h0;
    else
    begin
      if (clr_flags)
        flags[3:0] <= flags[3:0] & ~pwdata[3:0];
      if (wait_timeout)
        flags[FLG_TIMEOUT] <= 1'b1;
      if (pin_sync[0])
        flags[FLG_ALARM] <= 1'b1;
      if (pin_sync[1])
        flags[FLG_DEVIATION] <= 1'b1;
      if (pin_sync[2])
        flags[FLG_POSITION] <= 1'b1;
      if (do_run && f_instr == INS_COMPARE)
      begin
        flags[FLG_EQ] <= acc == operand;
        flags[FLG_GT] <= acc > operand;
        flags[FLG_LT] <= acc < operand;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gp_out <= '0;
    else if (do_run && f_instr == INS_WRITE_OUT && f_bank == BANK_OUTPUTS && f_type < 8'(OUT_COUNT))
      gp_out[f_type[1:0]] <= cmd_value[0];
  end

  // ----------------------------------------
  // reply frame
  // ----------------------------------------
  logic [7:0] next_status;
  logic [31:0] next_rvalue;
  always_comb
  begin
    next_status = STS_OK;
    next_rvalue = 32'h0;
    if (!sum_ok)
      next_status = STS_BAD_SUM;
    else if (!known)
      next_status = STS_BAD_INSTR;
    else if (f_instr == INS_READ_PORT)
      next_rvalue = port_value;
    else if (f_instr != INS_WRITE_OUT)
      next_rvalue = cmd_value;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reply_head <= 32'h0;
      reply_value <= 32'h0;
      reply_sum <= 8'h0;
      reply_valid <= 1'b0;
    end
    else if (go)
      reply_valid <= 1'b0;
    else if (state == ST_EXEC && for_me && !standalone)
    begin
      reply_head <= {host_addr, MODULE_ADDR, next_status, f_instr};
      reply_value <= next_rvalue;
      reply_sum <= sum8({host_addr, MODULE_ADDR, next_status, f_instr}, next_rvalue);
      reply_valid <= 1'b1;
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_head <= 32'h0;
      cmd_value <= 32'h0;
      cmd_sum <= 8'h0;
      standalone <= 1'b0;
      host_addr <= HOST_ADDR_RESET;
    end
    else if (wr_access && state == ST_IDLE)
      case (paddr)
        OFF_CMD_HEAD: cmd_head <= pwdata;
        OFF_CMD_VALUE: cmd_value <= pwdata;
        OFF_CMD_SUM: cmd_sum <= pwdata[7:0];
        OFF_CTRL:
        begin
          standalone <= pwdata[CTRL_STANDALONE];
          host_addr <= pwdata[CTRL_HOST_LSB +: 8];
        end
        default: ;
      endcase
  end

  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    case (paddr)
      OFF_CMD_HEAD: rd_mux = cmd_head;
      OFF_CMD_VALUE: rd_mux = cmd_value;
      OFF_CMD_SUM: rd_mux = {24'h0, cmd_sum};
      OFF_CTRL: rd_mux = {16'h0, host_addr, 7'h0, standalone};
      OFF_REPLY_HEAD: rd_mux = reply_head;
      OFF_REPLY_VALUE: rd_mux = reply_value;
      OFF_REPLY_SUM: rd_mux = {24'h0, reply_sum};
      OFF_STATUS: rd_mux = {30'h0, state != ST_IDLE, reply_valid};
      OFF_ACC: rd_mux = acc;
      OFF_PC: rd_mux = pc;
      OFF_FLAGS: rd_mux = {25'h0, flags};
      default:
      begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // no wait state: data and ready registered at setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      if (psel && !penable && !pwrite)
        prdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_run(logic [7:0] ins);
    state == ST_EXEC && for_me && sum_ok && f_instr == ins;
  endsequence
  a_accumulator_op_cmd_load: assert property (s_run(INS_ACCUMULATOR_OP_CMD) and (f_type == OP_LOAD) |=> acc == $past(cmd_value))
    else $error("load did not copy operand");
  a_accumulator_op_cmd_add: assert property (s_run(INS_ACCUMULATOR_OP_CMD) and (f_type == OP_ADD) |=> acc == $past(acc) + $past(cmd_value))
    else $error("add result wrong");
  a_accumulator_op_cmd_not: assert property (s_run(INS_ACCUMULATOR_OP_CMD) and (f_type == OP_NOT) |=> acc == ~$past(acc))
    else $error("invert result wrong");
  a_compare_hold: assert property (s_run(INS_COMPARE) |=> $stable(acc) && flags[FLG_EQ] == ($past(acc) == $past(operand)))
    else $error("compare touched accumulator or flags wrong");
  a_jump_taken: assert property (s_run(INS_JUMP_COND) and cond_true |=> pc == $past(cmd_value))
    else $error("jump not taken");
  a_jump_skip: assert property (s_run(INS_JUMP_COND) and !cond_true |=> pc == $past(pc) + 32'h1)
    else $error("false jump did not step");
  a_timeout_flag: assert property (wait_timeout |=> flags[FLG_TIMEOUT])
    else $error("timeout flag not set");
  a_reply_sum: assert property (state == ST_EXEC && for_me && !standalone |=> reply_valid && reply_sum == sum8(reply_head, reply_value))
    else $error("reply checksum wrong");
  a_reply_ok: assert property (s_run(INS_ACCUMULATOR_OP_CMD) and !standalone |=> reply_head[15:8] == STS_OK && reply_value == $past(cmd_value))
    else $error("accumulator_op_cmd reply wrong");
  a_enable_read: assert property (s_run(INS_READ_PORT) and (f_bank == BANK_INPUTS && f_type == PORT_ENABLE) and !standalone |=> reply_value == {31'h0, !$past(pin_sync[3])})
    else $error("enable read wrong");
  a_output_read: assert property (s_run(INS_READ_PORT) and (f_bank == BANK_OUTPUTS && f_type == 8'h00) and !standalone |=> reply_value[0] == gp_out[0])
    else $error("output read-back wrong");
  a_flag_cond: assert property (s_run(INS_JUMP_COND) and (f_type == CND_ALARM) and flags[FLG_ALARM] |=> pc == $past(cmd_value))
    else $error("alarm condition did not jump");
  a_cmp_cond: assert property (s_run(INS_JUMP_COND) and (f_type == CND_GREATER_EQUAL) |-> cond_true == (flags[FLG_GT] || flags[FLG_EQ]))
    else $error("greater-equal condition wrong");
  a_reply_order: assert property (s_run(INS_COMPARE) and !standalone |=> reply_head[7:0] == INS_COMPARE && reply_head[31:24] == host_addr)
    else $error("reply byte order wrong");
  a_compare_flags: assert property (s_run(INS_COMPARE) |=> flags[FLG_GT] == ($past(acc) > $past(operand)))
    else $error("greater flag wrong");
  a_accumulator_op_cmd_only: assert property (s_run(INS_ACCUMULATOR_OP_CMD) |=> $stable(pc) || pc == $past(pc) + 32'h1)
    else $error("accumulator_op_cmd disturbed program counter");
endmodule : accumulator_op_cmd_engine
`default_nettype wire

// ===== tb/accumulator_op_cmd_host.sv
// apb host model that frames commands for the engine
`timescale 1ns/1ns
`default_nettype none
module accumulator_op_cmd_host
#(
  parameter logic [7:0] TARGET = 8'h01 // arbitrary module address
)
(
  input wire logic pclk, // bus clock
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  output logic psel, // select
  output logic penable, // enable
  output logic pwrite, // direction
  output logic [7:0] paddr, // address
  output logic [31:0] pwdata // write data
);
  import accumulator_op_cmd_pkg::*;
  // ----------------
  // bus cycles
  // ----------------
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one idle edge after each transfer keeps psel from being driven twice in one step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask : wr
  function automatic logic [7:0] bsum(input logic [31:0] h, input logic [31:0] v);
    return h[31:24] + h[23:16] + h[15:8] + h[7:0] + v[31:24] + v[23:16] + v[15:8] + v[7:0];
  endfunction : bsum
  // ----------------
  // command frames
  // ----------------
  task automatic run(input logic [7:0] ins, input logic [7:0] typ, input logic [7:0] bank,
                     input logic [31:0] val, input logic sa, input logic bad);
    logic [31:0] hd;
    logic [31:0] q;
    hd = {TARGET, ins, typ, bank};
    wr(OFF_CMD_HEAD, hd);
    wr(OFF_CMD_VALUE, val);
    wr(OFF_CMD_SUM, {24'h0, bsum(hd, val) + {7'h0, bad}});
    // compare and jump as program steps
    wr(OFF_CTRL, {16'h0, HOST_ADDR_RESET, 6'h0, 1'b1, sa});
    // a stuck engine is caught by the bench timeout, which counts it
    do
      rd(OFF_STATUS, q);
    while (q[1] !== 1'b0);
  endtask : run
endmodule : accumulator_op_cmd_host
`default_nettype wire

// ===== tb/accumulator_accumulator_op_cmd_compare_jump_test.sv
// self-checking bench for the calculate, compare and jump engine
`timescale 1ns/1ns
`default_nettype none
module accumulator_accumulator_op_cmd_compare_jump_test;
  import accumulator_op_cmd_pkg::*;
  localparam logic [7:0] TGT = 8'h05; // arbitrary module address
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, acc, opnd, pcv, jadr, hd;
  logic wait_timeout, alarm_pin, deviation_pin, position_pin, enable_pin;
  logic [3:0] gp_out, exp_out, er;
  logic [2:0] cmpf;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  accumulator_op_cmd_engine #(.MODULE_ADDR(TGT)) i_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wait_timeout(wait_timeout),
    .alarm_pin(alarm_pin), .deviation_pin(deviation_pin), .position_pin(position_pin),
    .enable_pin(enable_pin), .gp_out(gp_out)
  );
  accumulator_op_cmd_host #(.TARGET(TGT)) i_host
  (
    .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
  );
  // ----------------
  // helpers
  // ----------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  function automatic logic [31:0] accumulator_op_cmd_exp(input int op, input logic signed [31:0] a, input logic signed [31:0] b);
    case (op)
      0: return a + b;
      1: return a - b;
      2: return a * b;
      3: return a / b;
      4: return a % b;
      5: return a & b;
      6: return a | b;
      7: return a ^ b;
      8: return ~a;
      default: return b;
    endcase
  endfunction : accumulator_op_cmd_exp
  // zero reads as equal after a compare
  function automatic logic cond_exp(input int c, input logic [2:0] f, input logic [3:0] x);
    case (c)
      0, 2: return f[0];
      1, 3: return !f[0];
      4: return f[1];
      5: return f[1] | f[0];
      6: return f[2];
      7: return f[2] | f[0];
      default: return x[c - 8];
    endcase
  endfunction : cond_exp
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end
  // ----------------
  // main sequence
  // ----------------
  initial
  begin
    presetn = 1'b0;
    wait_timeout = 1'b0;
    alarm_pin = 1'b0;
    deviation_pin = 1'b0;
    position_pin = 1'b0;
    enable_pin = 1'b1;
    q = $urandom(32'he21cbbc4);
    repeat (10) @(posedge pclk);
    check("reset outputs", {26'h0, pready, pslverr, gp_out}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int op = 0; op < 10; op++)
    begin
      acc = $urandom;
      opnd = $urandom;
      if (op == 3 || op == 4)
        opnd = {1'b0, opnd[30:4], 4'h3};
      i_host.run(INS_ACCUMULATOR_OP_CMD, OP_LOAD, 8'h00, acc, 1'b0, 1'b0);
      i_host.run(INS_ACCUMULATOR_OP_CMD, op[7:0], 8'ha5, opnd, 1'b0, 1'b0);
      i_host.rd(OFF_ACC, q);
      check("accumulator", q, accumulator_op_cmd_exp(op, acc, opnd));
      hd = {HOST_ADDR_RESET, TGT, STS_OK, INS_ACCUMULATOR_OP_CMD};
      i_host.rd(OFF_REPLY_HEAD, q);
      check("reply head", q, hd);
      i_host.rd(OFF_REPLY_VALUE, q);
      check("reply value", q, opnd);
      i_host.rd(OFF_REPLY_SUM, q);
      check("reply sum", q, {24'h0, i_host.bsum(hd, opnd)});
    end
    for (int c = 0; c < 12; c++)
    begin
      acc = $urandom_range(2000);
      acc = acc - 32'd1000;
      opnd = acc + $urandom_range(2) - 1;
      cmpf = {$signed(acc) < $signed(opnd), $signed(acc) > $signed(opnd), acc == opnd};
      i_host.run(INS_ACCUMULATOR_OP_CMD, OP_LOAD, 8'h00, acc, 1'b0, 1'b0);
      i_host.run(INS_COMPARE, 8'h33, 8'h44, opnd, 1'b1, 1'b0);
      i_host.rd(OFF_ACC, q);
      check("acc after compare", q, acc);
      i_host.rd(OFF_FLAGS, q);
      check("compare flags", {29'h0, q[6:4]}, {29'h0, cmpf});
      wait_timeout <= (c == 8);
      alarm_pin <= (c == 9);
      deviation_pin <= (c == 10);
      position_pin <= (c == 11);
      @(posedge pclk);
      {wait_timeout, alarm_pin, deviation_pin, position_pin} <= 4'h0;
      repeat (4) @(posedge pclk);
      // second pass runs with the error flags cleared
      for (int k = 0; k < 2; k++)
      begin
        er = (k == 0 && c >= 8) ? 4'h1 << (c - 8) : 4'h0;
        i_host.rd(OFF_FLAGS, q);
        check("error flags", {28'h0, q[3:0]}, {28'h0, er});
        i_host.rd(OFF_PC, pcv);
        // keeps the taken target apart from the stepped one
        jadr = pcv + 32'h100 + $urandom_range(63);
        i_host.run(INS_JUMP_COND, c[7:0], 8'h00, jadr, 1'b1, 1'b0);
        i_host.rd(OFF_PC, q);
        check("program counter", q, cond_exp(c, cmpf, er) ? jadr : pcv + 32'h1);
        i_host.wr(OFF_FLAGS, 32'hf);
      end
    end
    for (int r = 0; r < 3; r++)
    begin
      exp_out = 4'($urandom_range(15));
      for (int p = 0; p < OUT_COUNT; p++)
        i_host.run(INS_WRITE_OUT, p[7:0], BANK_OUTPUTS, {31'h0, exp_out[p]}, 1'b0, 1'b0);
      check("outputs", {28'h0, gp_out}, {28'h0, exp_out});
      for (int p = 0; p < OUT_COUNT; p++)
      begin
        i_host.run(INS_READ_PORT, p[7:0], BANK_OUTPUTS, 32'h0, 1'b0, 1'b0);
        i_host.rd(OFF_REPLY_VALUE, q);
        check("output read back", q, {31'h0, exp_out[p]});
      end
      enable_pin <= r[0];
      repeat (4) @(posedge pclk);
      i_host.run(INS_READ_PORT, PORT_ENABLE, BANK_INPUTS, 32'h0, 1'b0, 1'b0);
      i_host.rd(OFF_REPLY_VALUE, q);
      check("enable read", q, {31'h0, !r[0]});
      i_host.run(INS_READ_PORT, PORT_ENABLE, BANK_INPUTS, 32'h0, 1'b1, 1'b0);
      i_host.rd(OFF_ACC, q);
      check("enable into acc", q, {31'h0, !r[0]});
    end
    i_host.xfer(1'b0, 8'h3c, 32'h0, q, e);
    check("unmapped data", q, 32'h0);
    check("unmapped error", {31'h0, e}, 32'h1);
    i_host.rd(OFF_ACC, acc);
    i_host.run(INS_ACCUMULATOR_OP_CMD, OP_DIV, 8'h00, 32'h0, 1'b0, 1'b0);
    i_host.run(INS_ACCUMULATOR_OP_CMD, OP_LOAD, 8'h00, ~acc, 1'b0, 1'b1);
    i_host.rd(OFF_REPLY_HEAD, q);
    check("bad sum status", {24'h0, q[15:8]}, {24'h0, STS_BAD_SUM});
    i_host.run(8'h30, 8'h00, 8'h00, ~acc, 1'b0, 1'b0);
    i_host.rd(OFF_REPLY_HEAD, q);
    check("bad instr status", {24'h0, q[15:8]}, {24'h0, STS_BAD_INSTR});
    i_host.rd(OFF_ACC, q);
    check("acc kept", q, acc);
    end_sim();
  end
endmodule : accumulator_accumulator_op_cmd_compare_jump_test
`default_nettype wire
